// [logic/pfcseq_defs.vh]
// constants for the combined power-factor / resonant stage sequencer
// assumes a 100 MHz clock; millisecond delays use a 1 ms tick
`ifndef PFCSEQ_DEFS_VH
`define PFCSEQ_DEFS_VH

// ****************************************
// timebase
// ****************************************
`define PFCSEQ_CLK_MHZ        100
`define PFCSEQ_TICK_US        1000
`define PFCSEQ_TICK_CYC       (`PFCSEQ_CLK_MHZ * `PFCSEQ_TICK_US)
`define PFCSEQ_TICK_W         17
`define PFCSEQ_TICK_LAST      17'h1869f
`define PFCSEQ_START_DLY_MS   5'h14
`define PFCSEQ_STOP_DLY_MS    5'h05
`define PFCSEQ_MS_W           5

// ****************************************
// state codes
// ****************************************
`define PFCSEQ_ST_W           3
`define PFCSEQ_ST_OFF         3'h0
`define PFCSEQ_ST_WAIT        3'h1
`define PFCSEQ_ST_RUN         3'h2
`define PFCSEQ_ST_STOP        3'h3
`define PFCSEQ_ST_LATCH       3'h4
// synchronizer idle levels: on/off input idles high (off)
`define PFCSEQ_SYNC_RST       15'h0800

// ****************************************
// interrupt status / mask bits
// ****************************************
`define PFCSEQ_EV_W           4
`define PFCSEQ_EV_LATCH       0
`define PFCSEQ_EV_PGOOD       1
`define PFCSEQ_EV_STOP        2
`define PFCSEQ_EV_SOFT        3

// ****************************************
// register indices
// ****************************************
`define PFCSEQ_ADDR_W         4
`define PFCSEQ_REG_STATUS     4'h0
`define PFCSEQ_REG_MASK       4'h1
`define PFCSEQ_REG_STATE      4'h2
`define PFCSEQ_REG_CTRL       4'h3
`define PFCSEQ_MASK_RST       4'h0
`define PFCSEQ_CTRL_RST       1'b0

`endif

// [logic/pfcseq_msdelay.v]
// millisecond delay counter driven by the shared 1 ms tick
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps

`include "pfcseq_defs.vh"

module pfcseq_msdelay
  (
  // clock and reset
  input  wire                     clock,
  input  wire                     rst_b,
  // control
  input  wire                     tick,
  input  wire                     start,
  input  wire                     cancel,
  input  wire [`PFCSEQ_MS_W-1:0]  len,
  // status
  output reg                      done,
  output wire                     busy
  );

  reg  [`PFCSEQ_MS_W-1:0] cnt_r;
  reg                     run_r;

  assign busy = run_r;

  // restarts on each start pulse
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= {`PFCSEQ_MS_W{1'b0}};
      run_r <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_r <= len;
        run_r <= 1'b1;
      end
      else if (cancel)
        run_r <= 1'b0;
      else if (run_r && tick)
      begin
        if (cnt_r <= {{(`PFCSEQ_MS_W-1){1'b0}}, 1'b1})
        begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end
        else
          cnt_r <= cnt_r - {{(`PFCSEQ_MS_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [logic/pfcseq_top.v]
// sequencer and fault logic for a power-factor stage feeding a resonant stage
// assumes comparator flags arrive asynchronously; registers on a plain strobe port
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

`include "pfcseq_defs.vh"

// Operation
// - fast fault above soft threshold closes soft-start discharge switch
// - fast fault above latch threshold latches off both stages
// - discharge on brownout, stop expiry, fault, uvlo, pfc uvp, off, thermal
// - discharge switch stays closed until soft-start below reset level
// - discharge switch opens once resonant stage starts running
// - skip variant: low skip input suppresses both driver outputs
// - high-side driver off while floating-supply undervoltage reported
// - resonant drivers off while bulk-ready is low, except in the stop state
// - bulk-ready set above 95 percent bulk, cleared on line brownout
// - bulk-ready rise starts 20 ms delay; expiry asserts power good, drivers
// - falling bulk at power-good level releases power-good output
// - after release, stop at brownout level or 5 ms expiry, first wins
// - line brownout releases power good, drivers stop 5 ms later
// - remote on/off high stops both stages at once, low consumption
// - run only after supply above turn-on; off below lower threshold
// - latch cleared only by supply recycle, on/off toggle, or line brownout recycle
module pfcseq_top #(parameter [`PFCSEQ_TICK_W-1:0] TICK_LAST = `PFCSEQ_TICK_LAST)
  (
  // clock and reset
  input  wire                        clock,
  input  wire                        rst_b,
  // comparator flags, asynchronous
  input  wire                        fault_soft_threshold,
  input  wire                        fault_latch_threshold,
  input  wire                        bulk_ok_cmp,
  input  wire                        line_brownout,
  input  wire                        power_good_level_input,
  input  wire                        brownout_level_input,
  input  wire                        pfc_uvp,
  input  wire                        vcc_above_on,
  input  wire                        vcc_below_min,
  input  wire                        thermal_shutdown_flag,
  input  wire                        remote_off,
  input  wire                        skip_sense,
  input  wire                        ss_below_reset,
  input  wire                        boot_uvlo,
  // other latch sources
  input  wire                        pfc_latch_fault,
  // variant strap
  input  wire                        skip_variant,
  // stage controls
  output reg                         pfc_enable,
  output reg                         low_side_drive,
  output reg                         high_side_drive,
  output reg                         ss_discharge,
  output reg                         low_power,
  // power-good open drain
  output wire                        pgood_o,
  output reg                         pgood_oe,
  // register port
  input  wire [`PFCSEQ_ADDR_W-1:0]   reg_addr,
  input  wire [31:0]                 reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [31:0]                 reg_rdata,
  // interrupt
  output wire                        irq
  );

  // ****************************************
  // synchronizers
  // ****************************************
  localparam NSYNC = 15;
  wire [NSYNC-1:0] raw_in = {skip_sense, boot_uvlo, ss_below_reset, remote_off,
                             thermal_shutdown_flag, vcc_below_min, vcc_above_on,
                             pfc_uvp, brownout_level_input, power_good_level_input,
                             line_brownout, bulk_ok_cmp, fault_latch_threshold,
                             fault_soft_threshold, pfc_latch_fault};
  reg  [NSYNC-1:0] sync1_r;
  reg  [NSYNC-1:0] sync2_r;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= `PFCSEQ_SYNC_RST;
      sync2_r <= `PFCSEQ_SYNC_RST;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire s_pfclatch = sync2_r[0];
  wire s_ff1      = sync2_r[1];
  wire s_ff2      = sync2_r[2];
  wire s_bulk     = sync2_r[3];
  wire s_lbo      = sync2_r[4];
  wire s_pglvl    = sync2_r[5];
  wire s_bolvl    = sync2_r[6];
  wire s_uvp      = sync2_r[7];
  wire s_vccon    = sync2_r[8];
  wire s_vccmin   = sync2_r[9];
  wire s_tsd      = sync2_r[10];
  wire s_off      = sync2_r[11];
  wire s_ssrst    = sync2_r[12];
  wire s_bootuv   = sync2_r[13];
  wire s_skip     = sync2_r[14];

  // ****************************************
  // 1 ms tick
  // ****************************************
  reg [`PFCSEQ_TICK_W-1:0] div_r;
  reg                      tick_r;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r  <= {`PFCSEQ_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end
    else if (div_r == TICK_LAST)
    begin
      div_r  <= {`PFCSEQ_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + {{(`PFCSEQ_TICK_W-1){1'b0}}, 1'b1};
      tick_r <= 1'b0;
    end
  end

  // ****************************************
  // supply lockout with hysteresis
  // ****************************************
  reg vcc_ok_r;
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      vcc_ok_r <= 1'b0;
    else if (s_vccmin)
      vcc_ok_r <= 1'b0;
    else if (s_vccon)
      vcc_ok_r <= 1'b1;
  end

  // ****************************************
  // bulk-ready flag and edges
  // ****************************************
  reg bulk_ready_flag;
  reg bulk_prev_r;
  reg off_prev_r;
  reg lbo_prev_r;
  reg pgl_prev_r;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bulk_ready_flag <= 1'b0;
      bulk_prev_r     <= 1'b0;
      off_prev_r      <= 1'b1;
      lbo_prev_r      <= 1'b0;
      pgl_prev_r      <= 1'b0;
    end
    else
    begin
      if (s_lbo || !pfc_enable)
        bulk_ready_flag <= 1'b0;
      else if (s_bulk)
        bulk_ready_flag <= 1'b1;
      bulk_prev_r <= bulk_ready_flag;
      off_prev_r  <= s_off;
      lbo_prev_r  <= s_lbo;
      pgl_prev_r  <= s_pglvl;
    end
  end

  wire bulk_rise = bulk_ready_flag && !bulk_prev_r;
  wire bulk_fall = !bulk_ready_flag && bulk_prev_r;
  wire pgl_rise  = s_pglvl && !pgl_prev_r;
  wire off_rise  = s_off && !off_prev_r;
  wire lbo_fall  = !s_lbo && lbo_prev_r;

  // ****************************************
  // delay timers
  // ****************************************
  reg  [`PFCSEQ_ST_W-1:0] st_r;
  reg  [`PFCSEQ_ST_W-1:0] st_nxt;
  wire                    start_done;
  wire                    stop_done;
  wire                    start_busy;
  wire                    stop_busy;
  wire                    pg_release = (st_r == `PFCSEQ_ST_RUN) && (bulk_fall || pgl_rise);

  pfcseq_msdelay u_start_dly
    (
    .clock  (clock),
    .rst_b  (rst_b),
    .tick   (tick_r),
    .start  (bulk_rise),
    .cancel (!bulk_ready_flag),
    .len    (`PFCSEQ_START_DLY_MS),
    .done   (start_done),
    .busy   (start_busy)
    );

  pfcseq_msdelay u_stop_dly
    (
    .clock  (clock),
    .rst_b  (rst_b),
    .tick   (tick_r),
    .start  (pg_release),
    .cancel (st_r != `PFCSEQ_ST_STOP),
    .len    (`PFCSEQ_STOP_DLY_MS),
    .done   (stop_done),
    .busy   (stop_busy)
    );

  // ****************************************
  // sequencer
  // ****************************************
  wire stop_all  = !vcc_ok_r || s_off || s_tsd;
  wire latch_hit = s_ff2 || s_pfclatch;
  wire latch_clr = !vcc_ok_r || off_rise || lbo_fall;

  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      `PFCSEQ_ST_OFF:
        if (!stop_all)
          st_nxt = `PFCSEQ_ST_WAIT;
      `PFCSEQ_ST_WAIT:
        if (start_done && bulk_ready_flag)
          st_nxt = `PFCSEQ_ST_RUN;
      `PFCSEQ_ST_RUN:
        if (pg_release)
          st_nxt = `PFCSEQ_ST_STOP;
      `PFCSEQ_ST_STOP:
        if (stop_done || s_bolvl)
          st_nxt = `PFCSEQ_ST_WAIT;
      `PFCSEQ_ST_LATCH:
        if (latch_clr)
          st_nxt = `PFCSEQ_ST_OFF;
      default:
        st_nxt = `PFCSEQ_ST_OFF;
    endcase
    if (st_r != `PFCSEQ_ST_LATCH)
    begin
      if (latch_hit)
        st_nxt = `PFCSEQ_ST_LATCH;
      else if (stop_all)
        st_nxt = `PFCSEQ_ST_OFF;
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= `PFCSEQ_ST_OFF;
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // soft-start discharge
  // ****************************************
  reg  ss_hold_r;
  wire ss_trig = s_bolvl || stop_done || s_ff1 || !vcc_ok_r || s_uvp || s_off || s_tsd;
  wire latched = (st_r == `PFCSEQ_ST_LATCH);

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ss_hold_r <= 1'b1;
    else if (ss_trig || latched)
      ss_hold_r <= 1'b1;
    else if (s_ssrst && st_r == `PFCSEQ_ST_RUN)
      ss_hold_r <= 1'b0;
  end

  // ****************************************
  // outputs
  // ****************************************
  wire drv_on = (st_r == `PFCSEQ_ST_RUN || st_r == `PFCSEQ_ST_STOP) && !latched;
  wire skip_cut = skip_variant && !s_skip;
  wire pulses = drv_on && (bulk_ready_flag || st_r == `PFCSEQ_ST_STOP) && !skip_cut;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pfc_enable      <= 1'b0;
      low_side_drive  <= 1'b0;
      high_side_drive <= 1'b0;
      ss_discharge    <= 1'b1;
      low_power       <= 1'b1;
      pgood_oe        <= 1'b0;
    end
    else
    begin
      pfc_enable      <= (st_nxt != `PFCSEQ_ST_OFF) && (st_nxt != `PFCSEQ_ST_LATCH);
      low_side_drive  <= pulses && (bulk_ready_flag || st_r == `PFCSEQ_ST_STOP);
      high_side_drive <= pulses && !s_bootuv;
      ss_discharge    <= ss_hold_r || ss_trig || latched;
      low_power       <= s_off;
      pgood_oe        <= (st_nxt == `PFCSEQ_ST_RUN);
    end
  end

  assign pgood_o = 1'b0;

  // ****************************************
  // registers and interrupt
  // ****************************************
  reg  [`PFCSEQ_EV_W-1:0] stat_r;
  reg  [`PFCSEQ_EV_W-1:0] mask_r;
  reg                     ctrl_r;
  wire [`PFCSEQ_EV_W-1:0] ev;

  assign ev[`PFCSEQ_EV_LATCH] = latched && !(st_r == st_nxt) ? 1'b0 : (st_nxt == `PFCSEQ_ST_LATCH) && !latched;
  assign ev[`PFCSEQ_EV_PGOOD] = pg_release;
  assign ev[`PFCSEQ_EV_STOP]  = stop_done;
  assign ev[`PFCSEQ_EV_SOFT]  = s_ff1;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_r    <= {`PFCSEQ_EV_W{1'b0}};
      mask_r    <= `PFCSEQ_MASK_RST;
      ctrl_r    <= `PFCSEQ_CTRL_RST;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      // set wins over read-clear
      if (reg_rd && reg_addr == `PFCSEQ_REG_STATUS)
        stat_r <= ev;
      else
        stat_r <= stat_r | ev;
      if (reg_wr && reg_addr == `PFCSEQ_REG_MASK)
        mask_r <= reg_wdata[`PFCSEQ_EV_W-1:0];
      if (reg_wr && reg_addr == `PFCSEQ_REG_CTRL)
        ctrl_r <= reg_wdata[0];
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `PFCSEQ_REG_STATUS: reg_rdata <= {28'h000_0000, stat_r};
          `PFCSEQ_REG_MASK:   reg_rdata <= {28'h000_0000, mask_r};
          `PFCSEQ_REG_STATE:  reg_rdata <= {24'h00_0000, bulk_ready_flag, vcc_ok_r,
                                            start_busy, stop_busy, 1'b0, st_r};
          `PFCSEQ_REG_CTRL:   reg_rdata <= {31'h0000_0000, ctrl_r};
          default:            reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ctrl bit 0 holds the interrupt line off globally
  assign irq = |(stat_r & mask_r) && !ctrl_r;

endmodule

// [verif/pfcseq_chk_sva.sv]
// assertions on the sequencer top ports
// assumes binding onto pfcseq_top; one clock, async low reset
`timescale 1ns/1ps
module pfcseq_chk
  (
  // clock and reset
  input wire        clock,
  input wire        rst_b,
  // flags
  input wire        fault_soft_threshold,
  input wire        fault_latch_threshold,
  input wire        thermal_shutdown_flag,
  input wire        pfc_uvp,
  input wire        vcc_below_min,
  input wire        remote_off,
  input wire        skip_sense,
  input wire        skip_variant,
  input wire        boot_uvlo,
  // controls
  input wire        pfc_enable,
  input wire        low_side_drive,
  input wire        high_side_drive,
  input wire        ss_discharge,
  input wire        low_power,
  input wire        pgood_oe,
  input wire        reg_rd,
  input wire [31:0] reg_rdata
  );
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence latch_hit;
    fault_latch_threshold [*3];
  endsequence
  sequence halted;
    !pfc_enable && !low_side_drive && !high_side_drive && !pgood_oe && ss_discharge;
  endsequence

  latch_off_a: assert property (latch_hit |-> ##[0:4] halted)
    else $error("latch did not halt both stages");
  soft_fault_a: assert property (fault_soft_threshold [*4] |-> ##[0:4] ss_discharge)
    else $error("soft fault left discharge open");
  ss_trigger_a: assert property ((thermal_shutdown_flag || pfc_uvp || remote_off || vcc_below_min) [*5]
    |-> ss_discharge)
    else $error("discharge open during a trigger");
  ss_release_a: assert property ($fell(ss_discharge) |-> $past(pgood_oe))
    else $error("discharge released outside run");
  remote_stop_a: assert property (remote_off [*4] |-> ##[0:4] (low_power && !pfc_enable && !low_side_drive))
    else $error("off request did not stop stages");
  boot_gate_a: assert property (boot_uvlo [*5] |-> !high_side_drive)
    else $error("high side on with low upper supply");
  skip_cut_a: assert property ((skip_variant && !skip_sense) [*5] |-> !low_side_drive && !high_side_drive)
    else $error("pulses during skip");
  vcc_off_a: assert property (vcc_below_min [*6] |-> !pfc_enable && !pgood_oe && !low_side_drive)
    else $error("running below supply minimum");
  pgood_run_a: assert property ($rose(pgood_oe) |-> pfc_enable && !low_power)
    else $error("power good without running stage");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind pfcseq_top pfcseq_chk u_pfcseq_chk
  (.clock(clock), .rst_b(rst_b), .fault_soft_threshold(fault_soft_threshold),
   .fault_latch_threshold(fault_latch_threshold), .thermal_shutdown_flag(thermal_shutdown_flag),
   .pfc_uvp(pfc_uvp), .vcc_below_min(vcc_below_min), .remote_off(remote_off), .skip_sense(skip_sense),
   .skip_variant(skip_variant), .boot_uvlo(boot_uvlo), .pfc_enable(pfc_enable),
   .low_side_drive(low_side_drive), .high_side_drive(high_side_drive), .ss_discharge(ss_discharge),
   .low_power(low_power), .pgood_oe(pgood_oe), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// [verif/pfcseq_sup.sv]
// secondary-side supervisor on the on/off and power-good lines
// assumes want_on comes from the bench; power-good line has a pull-up
`timescale 1ns/1ps
module pfcseq_sup
  (
  // clock and reset
  input  wire clock,
  input  wire rst_b,
  // bench side
  input  wire want_on,
  output wire pg_line,
  // device side
  input  wire pgood_oe,
  output reg  remote_off
  );
  // ****************************************
  // on/off drive and power-good line
  // ****************************************
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
      remote_off <= 1'b1;
    else
      remote_off <= !want_on;

  // released line floats to the pull-up level
  assign pg_line = pgood_oe ? 1'b0 : 1'b1;
endmodule

// [verif/tb.sv]
// self-checking bench for the power-factor / resonant sequencer
// assumes a 50-cycle tick in the design, so the 20 ms and 5 ms delays fit the run
`timescale 1ns/1ps
`include "pfcseq_defs.vh"
module tb;
  // ****************************************
  // design, partner and helpers
  // ****************************************
  reg                       clock, rst_b, fault_soft_threshold, fault_latch_threshold, bulk_ok_cmp, line_brownout;
  reg                       power_good_level_input, brownout_level_input, pfc_uvp, vcc_above_on, vcc_below_min;
  reg                       thermal_shutdown_flag, skip_sense, ss_below_reset, boot_uvlo, pfc_latch_fault;
  reg                       skip_variant, reg_wr, reg_rd, want_on;
  reg  [`PFCSEQ_ADDR_W-1:0] reg_addr, mk;
  reg  [31:0]               reg_wdata, d, r;
  wire [31:0]               reg_rdata;
  wire                      remote_off, pfc_enable, low_side_drive, high_side_drive, ss_discharge, low_power;
  wire                      pgood_o, pgood_oe, irq, pg_line;
  integer                   seed, i, j, err_count, tests_run;

  pfcseq_top #(.TICK_LAST(17'h00031)) u_pfcseq_top
    (.clock(clock), .rst_b(rst_b), .fault_soft_threshold(fault_soft_threshold),
     .fault_latch_threshold(fault_latch_threshold), .bulk_ok_cmp(bulk_ok_cmp), .line_brownout(line_brownout),
     .power_good_level_input(power_good_level_input), .brownout_level_input(brownout_level_input),
     .pfc_uvp(pfc_uvp), .vcc_above_on(vcc_above_on), .vcc_below_min(vcc_below_min),
     .thermal_shutdown_flag(thermal_shutdown_flag), .remote_off(remote_off), .skip_sense(skip_sense),
     .ss_below_reset(ss_below_reset), .boot_uvlo(boot_uvlo), .pfc_latch_fault(pfc_latch_fault),
     .skip_variant(skip_variant), .pfc_enable(pfc_enable), .low_side_drive(low_side_drive),
     .high_side_drive(high_side_drive), .ss_discharge(ss_discharge), .low_power(low_power),
     .pgood_o(pgood_o), .pgood_oe(pgood_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
     .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  pfcseq_sup u_pfcseq_sup (.clock(clock), .rst_b(rst_b), .want_on(want_on), .pg_line(pg_line),
                           .pgood_oe(pgood_oe), .remote_off(remote_off));

  always #5 clock = ~clock;

  function [31:0] exp_state(input bulk, input vok, input sbusy, input [2:0] st);
    exp_state = {24'h0, bulk, vok, sbusy, 2'b00, st};
  endfunction
  function exp_irq(input [3:0] st, input [3:0] m, input dis);
    exp_irq = |(st & m) && !dis;
  endfunction

  task chk32(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task chk1(input got, input exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task settle;
  begin
    repeat (8) @(posedge clock);
    #1;
  end
  endtask
  task wr(input [3:0] a, input [31:0] v);
  begin
    @(posedge clock) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clock) reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, output [31:0] v);
  begin
    @(posedge clock) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  end
  endtask
  task conclude;
  begin
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  initial
  begin
    #400000;
    err_count = err_count + 1;
    conclude;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {clock, rst_b, fault_soft_threshold, fault_latch_threshold, bulk_ok_cmp, line_brownout} = 6'h0;
    {power_good_level_input, brownout_level_input, pfc_uvp, vcc_above_on, vcc_below_min} = 5'h0;
    {thermal_shutdown_flag, skip_sense, ss_below_reset, boot_uvlo, pfc_latch_fault} = 5'h0;
    {reg_wr, reg_rd, want_on, reg_addr, reg_wdata} = 39'h0;
    skip_variant = 1'b1;
    seed = 32'h5b86;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    #1;
    chk1(ss_discharge, 1'b1);
    chk1(low_power, 1'b1);
    @(posedge clock) rst_b <= 1'b1;
    settle;
    r = $random(seed);
    wr(4'h1, {28'h0, r[3:0]});
    rd(4'h1, d);
    chk32(d, {28'h0, r[3:0]});
    wr(4'h3, 32'h1);
    rd(4'h3, d);
    chk32(d, 32'h1);
    mk = 4'h4 + r[7:4] % 4'hc;
    wr(mk, r);
    rd(mk, d);
    chk32(d, 32'h0);
    @(posedge clock) {vcc_above_on, want_on} <= 2'b11;
    settle;
    chk1(pfc_enable, 1'b1);
    @(posedge clock) bulk_ok_cmp <= 1'b1;
    settle;
    rd(4'h2, d);
    chk32(d, exp_state(1'b1, 1'b1, 1'b1, 3'h1));
    chk1(pgood_oe, 1'b0);
    chk1(low_side_drive, 1'b0);
    @(posedge clock) line_brownout <= 1'b1;
    settle;
    rd(4'h2, d);
    chk1(d[7], 1'b0);
    @(posedge clock) line_brownout <= 1'b0;
    settle;
    rd(4'h0, d);
    for (i = 0; i < 3; i = i + 1)
    begin
      mk = (i == 1) ? 4'h0 : 4'h8;
      wr(4'h1, {28'h0, mk});
      wr(4'h3, {31'h0, i == 2});
      @(posedge clock) fault_soft_threshold <= 1'b1;
      settle;
      chk1(ss_discharge, 1'b1);
      @(posedge clock) fault_soft_threshold <= 1'b0;
      settle;
      chk1(irq, exp_irq(4'h8, mk, i == 2));
      rd(4'h0, d);
      chk1(d[3], 1'b1);
      chk1(irq, 1'b0);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge clock) {pfc_latch_fault, fault_latch_threshold} <= (i == 2) ? 2'b10 : 2'b01;
      settle;
      @(posedge clock) {pfc_latch_fault, fault_latch_threshold} <= 2'b00;
      settle;
      rd(4'h2, d);
      chk32(d & 32'h7, 32'h4);
      chk1(pfc_enable, 1'b0);
      chk1(pg_line, 1'b1);
      if (i == 0)
        @(posedge clock) want_on <= 1'b0;
      else if (i == 1)
        @(posedge clock) line_brownout <= 1'b1;
      else
        @(posedge clock) {vcc_above_on, vcc_below_min} <= 2'b01;
      settle;
      @(posedge clock) {want_on, line_brownout, vcc_above_on, vcc_below_min} <= 4'b1010;
      settle;
      rd(4'h2, d);
      chk32(d & 32'h7, 32'h1);
      chk1(pfc_enable, 1'b1);
    end
    for (j = 0; j < 6; j = j + 1)
    begin
      r = $random(seed);
      @(posedge clock) {thermal_shutdown_flag, pfc_uvp, skip_sense, boot_uvlo, ss_below_reset,
                        power_good_level_input, brownout_level_input} <= {j[0], !j[0], r[4:0]};
      settle;
      chk1(ss_discharge, 1'b1);
    end
    @(posedge clock) {thermal_shutdown_flag, pfc_uvp, skip_sense, boot_uvlo, ss_below_reset,
                      power_good_level_input, brownout_level_input} <= 7'h14;
    settle;
    // pass 0: release by power-good level, stop on delay; pass 1: line brownout, stop on brownout level
    for (i = 0; i < 2; i = i + 1)
    begin
      repeat (890) @(posedge clock);
      #1;
      chk1(pg_line, 1'b1);
      repeat (200) @(posedge clock);
      #1;
      chk32({pg_line, low_side_drive, high_side_drive, ss_discharge, pgood_o}, 32'hc);
      @(posedge clock) skip_sense <= 1'b0;
      settle;
      chk32({low_side_drive, high_side_drive}, 32'h0);
      @(posedge clock) {skip_sense, boot_uvlo} <= 2'b11;
      settle;
      chk32({low_side_drive, high_side_drive}, 32'h2);
      if (i == 0)
        @(posedge clock) {boot_uvlo, power_good_level_input} <= 2'b01;
      else
        @(posedge clock) {boot_uvlo, line_brownout} <= 2'b01;
      settle;
      chk32({pg_line, low_side_drive}, 32'h3);
      repeat (150) @(posedge clock);
      #1;
      chk1(low_side_drive, 1'b1);
      if (i == 0)
        repeat (110) @(posedge clock);
      else
        @(posedge clock) brownout_level_input <= 1'b1;
      settle;
      chk32({low_side_drive, ss_discharge}, 32'h1);
      rd(4'h0, d);
      chk32(d, (i == 0) ? 32'h7 : 32'h2);
      @(posedge clock) {line_brownout, power_good_level_input, brownout_level_input} <= 3'b100;
      settle;
      @(posedge clock) line_brownout <= 1'b0;
      settle;
    end
    settle;
    @(posedge clock) want_on <= 1'b0;
    settle;
    chk1(low_power, 1'b1);
    chk1(pfc_enable, 1'b0);
    conclude;
  end
endmodule
